// ### verif/sdf_decim_props.sv
`timescale 1ns/1ps
module sdf_decim_props
  import sdf_pkg::*;
#(
  parameter logic [SDF_NUM_OSR-1:0][15:0] SETTLE_TAB = SDF_SETTLE_TAB
) (
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // Controls
  input wire logic   resync,
  input wire logic   cfg_change,
  input wire logic   sample_ack,
  // Samples and status
  input sdf_sample_t sample_out,
  input wire logic   sample_valid,
  input wire logic   conversion_ready_n,
  input wire logic   settle_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Conversions since reset; a resync must not clear it.
  logic [1:0] conv_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_r <= 2'h0;
    end else if (sample_valid && conv_r != 2'h3) begin
      conv_r <= conv_r + 2'h1;
    end
  end

  sequence s_ready_low;
    sample_valid ##1 !conversion_ready_n;
  endsequence
  sequence s_reassert;
    sample_valid ##1 conversion_ready_n ##1 !conversion_ready_n;
  endsequence

  a_valid_pulse: assert property (sample_valid |=> !sample_valid [*8])
    else $error("sample_valid too long");
  a_ready_first: assert property (sample_valid && conversion_ready_n |-> s_ready_low)
    else $error("ready did not fall");
  a_ready_again: assert property (sample_valid && !conversion_ready_n |-> s_reassert)
    else $error("ready not pulsed again");
  a_ready_cause: assert property ($fell(conversion_ready_n) |->
    $past(sample_valid) || $past(sample_valid, 2)) else $error("ready fell alone");
  a_ack_release: assert property (!conversion_ready_n && sample_ack && !sample_valid
    |=> conversion_ready_n) else $error("ack ignored");
  a_out_then_valid: assert property ($changed(sample_out) |-> ##[0:1] sample_valid)
    else $error("sample without valid");
  a_fast_first: assert property (sample_valid && conv_r < 2'h2 |-> sample_out.fast)
    else $error("early sample not fast");
  a_sinc3_after: assert property (sample_valid && conv_r > 2'h1 |-> !sample_out.fast)
    else $error("late sample fast");
  a_resync_clears: assert property (resync |=> !settle_done [*8])
    else $error("resync kept settled");
  a_cfg_restarts: assert property (cfg_change |=> !settle_done)
    else $error("change kept settled");
endmodule

bind sdf_decim sdf_decim_props #(.SETTLE_TAB(SETTLE_TAB)) sdf_decim_props_i (
  .clk(clk), .rst_n(rst_n), .resync(resync), .cfg_change(cfg_change),
  .sample_ack(sample_ack), .sample_out(sample_out), .sample_valid(sample_valid),
  .conversion_ready_n(conversion_ready_n), .settle_done(settle_done)
);

// ### verif/sdf_mod_model.sv
`timescale 1ns/1ps
module sdf_mod_model #(
  parameter int HALF_NS = 40
) (
  // Stream level chosen by the bench
  input  wire logic level,
  // Modulator pins
  output logic      master_clock_in,
  output logic      mod_bit
);
  // Master clock, free running.
  // It never stops, since the converter needs it between conversions as well.
  initial master_clock_in = 1'h0;
  always #(HALF_NS) master_clock_in = ~master_clock_in;
  initial mod_bit = 1'h0;
  always @(negedge master_clock_in) mod_bit <= level;
endmodule

// ### verif/tb_sdf_decim.sv
`timescale 1ns/1ps
module tb_sdf_decim;
  import sdf_pkg::*;
  // Short settling so both settle checks fit the run: 32 master edges.
  localparam logic [SDF_NUM_OSR-1:0][15:0] TAB = {SDF_NUM_OSR{16'h0020}};
  logic        clk;
  logic        rst_n;
  logic        master_clock_in;
  logic        mod_bit;
  logic        level;
  logic [2:0]  osr_sel;
  logic        resync;
  logic        cfg_change;
  logic        sample_ack;
  sdf_sample_t sample_out;
  logic        sample_valid;
  logic        conversion_ready_n;
  logic        settle_done;
  int          error_cnt;
  int          tests_run;
  time         t0;

  // Master period 40 ns keeps its edges off clk rising edges; sync delay stays fixed.
  // The fast master keeps the two-stage ratio inside the run time.
  sdf_mod_model #(.HALF_NS(20)) sdf_mod_model_i (.level(level), .master_clock_in(master_clock_in),
    .mod_bit(mod_bit));
  sdf_decim #(.OSR_W(3), .SETTLE_TAB(TAB)) sdf_decim_i (.clk(clk), .rst_n(rst_n),
    .master_clock_in(master_clock_in), .mod_bit(mod_bit), .osr_sel(osr_sel),
    .resync(resync), .cfg_change(cfg_change), .sample_out(sample_out),
    .sample_valid(sample_valid), .sample_ack(sample_ack),
    .conversion_ready_n(conversion_ready_n), .settle_done(settle_done));

  always #5 clk = ~clk;

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task automatic wait_valid;
    int n;
    n = 0;
    step(1);
    while (sample_valid !== 1'h1 && n < 40000) begin
      step(1);
      n++;
    end
    chk("sample_valid", sample_valid, 1'h1);
  endtask
  task automatic restart;
    resync = 1'h1;
    step(1);
    resync = 1'h0;
  endtask
  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic t_startup;
    wait_valid();
    t0 = $time;
    chk("fast", sample_out.fast, 1'h1);
    chk("data", sample_out.data, 24'h7FFFFF);
    step(1);
    chk("ready", conversion_ready_n, 1'h0);
    sample_ack = 1'h1;
    step(1);
    sample_ack = 1'h0;
    chk("ready", conversion_ready_n, 1'h1);
    wait_valid();
    chk("period", 32'($time - t0), 80 * 64);
    chk("fast", sample_out.fast, 1'h1);
    repeat (3) wait_valid();
    chk("fast", sample_out.fast, 1'h0);
    chk("data", sample_out.data, 24'h7FFFFF);
  endtask
  task automatic t_level;
    level = 1'h0;
    restart();
    repeat (4) wait_valid();
    chk("data", sample_out.data, 24'h800000);
    chk("fast", sample_out.fast, 1'h0);
  endtask
  task automatic t_ratios;
    for (int k = 0; k < 6; k++) begin
      osr_sel = 3'(k);
      restart();
      wait_valid();
      t0 = $time;
      wait_valid();
      chk("period", 32'($time - t0), 80 * (64 << k));
    end
    wait_valid();
    chk("data", sample_out.data, 24'h800000);
    chk("fast", sample_out.fast, 1'h0);
  endtask
  task automatic t_settle;
    chk("settle_tab", 32'(SDF_SETTLE_TAB[0]), 728);
    chk("settle_tab", 32'(SDF_SETTLE_TAB[4]), 2648);
    chk("settle_tab", 32'(SDF_SETTLE_TAB[8]), 33368);
    restart();
    chk("settle", settle_done, 1'h0);
    step(100);
    chk("settle", settle_done, 1'h0);
    step(100);
    chk("settle", settle_done, 1'h1);
    cfg_change = 1'h1;
    step(1);
    cfg_change = 1'h0;
    chk("settle", settle_done, 1'h0);
    step(300);
    chk("settle", settle_done, 1'h1);
  endtask

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    level = 1'h1;
    osr_sel = 3'h0;
    resync = 1'h0;
    cfg_change = 1'h0;
    sample_ack = 1'h0;
    error_cnt = 0;
    tests_run = 0;
    step(10);
    rst_n = 1'h1;
    t_startup();
    t_level();
    t_ratios();
    t_settle();
    conclude();
  end
  initial begin
    #950000;
    error_cnt++;
    conclude();
  end
endmodule

// ### verilog/sdf_decim.sv
`timescale 1ns/1ps
module sdf_decim
  import sdf_pkg::*;
#(
  parameter int                                OSR_W      = SDF_OSR_W,
  parameter logic [SDF_NUM_OSR-1:0][15:0]      SETTLE_TAB = SDF_SETTLE_TAB
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Modulator pins
  input  wire logic              master_clock_in,
  input  wire logic              mod_bit,
  // Control from configuration logic
  input  wire logic [OSR_W-1:0]  osr_sel,
  input  wire logic              resync,
  input  wire logic              cfg_change,
  // Samples toward calibration logic
  output sdf_sample_t            sample_out,
  output logic                   sample_valid,
  input  wire logic              sample_ack,
  output logic                   conversion_ready_n,
  // Status
  output logic                   settle_done
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] osr_index(input logic [OSR_W-1:0] sel);
    logic [31:0] s;
    s = 32'(sel);
    // [R16] ascending ratio map
    if (s >= SDF_NUM_OSR) begin
      return 4'(SDF_NUM_OSR - 1);
    end
    return s[3:0];
  endfunction

  function automatic logic [14:0] pow2_m1(input logic [4:0] l);
    return 15'((32'h1 << l) - 32'h1);
  endfunction

  function automatic logic [SDF_OUT_W-1:0] norm(input logic signed [SDF_NORM_W-1:0] v,
                                                input logic [5:0] fs);
    logic [SDF_NORM_W-1:0] sh;
    sh = v <<< (6'd47 - fs);
    // Only an all-ones input reaches plus full scale; clamp it.
    if (v > 0 && sh[SDF_NORM_W-1]) begin
      return 24'h7FFFFF;
    end
    return sh[SDF_NORM_W-1 -: SDF_OUT_W];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and modulator tick
  // ----------------------------------------------------------------
  logic mclk_s1_r, mclk_s2_r, mclk_s3_r;
  logic mbit_s1_r, mbit_s2_r;
  logic half_r;
  logic mclk_rise;
  logic mod_tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_s1_r <= 1'b0;
      mclk_s2_r <= 1'b0;
      mclk_s3_r <= 1'b0;
      mbit_s1_r <= 1'b0;
      mbit_s2_r <= 1'b0;
    end else begin
      mclk_s1_r <= master_clock_in;
      mclk_s2_r <= mclk_s1_r;
      mclk_s3_r <= mclk_s2_r;
      mbit_s1_r <= mod_bit;
      mbit_s2_r <= mbit_s1_r;
    end
  end

  assign mclk_rise = mclk_s2_r & ~mclk_s3_r;

  // [R15] modulator at half master
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r <= 1'b0;
    end else if (mclk_rise) begin
      half_r <= ~half_r;
    end
  end

  // [R4] rate follows master pin
  assign mod_tick = mclk_rise & half_r;

  // ----------------------------------------------------------------
  // Ratio decode and phase counter
  // ----------------------------------------------------------------
  logic [3:0]  idx;
  logic [4:0]  l_all;
  logic [4:0]  l_s3;
  logic        use_s1;
  logic [14:0] ph_r;
  logic        s3_end;
  logic        all_end;

  // [R3] ratio field decode
  assign idx     = osr_index(osr_sel);
  assign l_all   = SDF_OSR_LOG2_0 + 5'(idx);
  assign use_s1  = l_all > SDF_S3_LOG2MAX;
  // [R9] third-order stage capped at 1024
  assign l_s3    = use_s1 ? SDF_S3_LOG2MAX : l_all;
  assign s3_end  = mod_tick && ((ph_r & pow2_m1(l_s3)) == pow2_m1(l_s3));
  // [R2] one sample per ratio count
  assign all_end = mod_tick && (ph_r == pow2_m1(l_all));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 15'h0000;
    end else if (resync || all_end) begin
      ph_r <= 15'h0000;
    end else if (mod_tick) begin
      ph_r <= ph_r + 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Third-order integrators and combs
  // ----------------------------------------------------------------
  logic signed [SDF_S3_W-1:0]   x;
  logic signed [SDF_S3_W-1:0]   i1_r, i2_r, i3_r;
  logic signed [SDF_S3_W-1:0]   z0_r, z1_r, z2_r;
  logic signed [SDF_S3_W-1:0]   c1, c2, c3;
  logic signed [SDF_S1_W-1:0]   s1_acc_r;
  logic signed [SDF_S1_W-1:0]   s1_sum;
  logic signed [SDF_FAST_W-1:0] f_acc_r;
  logic signed [SDF_FAST_W-1:0] f_sum;

  // [R1] one-bit stream as plus or minus one
  assign x = mbit_s2_r ? 32'sh00000001 : 32'shFFFFFFFF;

  // [R5] both paths see every modulator sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i1_r <= '0;
      i2_r <= '0;
      i3_r <= '0;
    end else if (resync) begin
      // [R17] resync clears integrators
      i1_r <= '0;
      i2_r <= '0;
      i3_r <= '0;
    end else if (mod_tick) begin
      i1_r <= i1_r + x;
      i2_r <= i2_r + i1_r;
      i3_r <= i3_r + i2_r;
    end
  end

  // Wrapping arithmetic is safe: the comb differences are exact modulo 2^32.
  assign c1 = i3_r - z0_r;
  assign c2 = c1 - z1_r;
  assign c3 = c2 - z2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      z0_r <= '0;
      z1_r <= '0;
      z2_r <= '0;
    end else if (resync) begin
      // [R17] resync clears combs
      z0_r <= '0;
      z1_r <= '0;
      z2_r <= '0;
    end else if (s3_end) begin
      z0_r <= i3_r;
      z1_r <= c1;
      z2_r <= c2;
    end
  end

  // [R9] first-order stage after 1024
  assign s1_sum = s1_acc_r + SDF_S1_W'(c3);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_acc_r <= '0;
    end else if (resync || all_end) begin
      s1_acc_r <= '0;
    end else if (s3_end) begin
      s1_acc_r <= s1_sum;
    end
  end

  // ----------------------------------------------------------------
  // Fast-settling path
  // ----------------------------------------------------------------
  assign f_sum = f_acc_r + SDF_FAST_W'(x);

  // [R6] first-order boxcar over the whole ratio
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_acc_r <= '0;
    end else if (resync || all_end) begin
      f_acc_r <= '0;
    end else if (mod_tick) begin
      f_acc_r <= f_sum;
    end
  end

  // ----------------------------------------------------------------
  // Path selection and output
  // ----------------------------------------------------------------
  logic [1:0]           conv_r;
  logic                 sel_fast;
  logic [SDF_OUT_W-1:0] s3_norm;
  logic [SDF_OUT_W-1:0] f_norm;
  logic                 reassert_r;

  // [R7] two fast conversions, then third-order until reset
  assign sel_fast = conv_r < SDF_FAST_CONVS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_r <= 2'h0;
    end else if (all_end && sel_fast) begin
      conv_r <= conv_r + 2'h1;
    end
  end

  // [R8] direct third-order result up to 1024
  // [R10] boxcar sums place nulls at output-rate multiples
  assign s3_norm = use_s1 ? norm(SDF_NORM_W'(s1_sum), 6'(l_all) + 6'h14)
                          : norm(SDF_NORM_W'(c3), 6'(l_s3) * 6'h03);
  assign f_norm  = norm(SDF_NORM_W'(f_sum), 6'(l_all));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_out   <= '0;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= all_end;
      if (all_end) begin
        sample_out.data <= sel_fast ? f_norm : s3_norm;
        sample_out.fast <= sel_fast;
      end
    end
  end

  // A new sample over an unacknowledged one forces a high cycle first, so each sample
  // shows its own falling edge.
  // [R13] ready never gated by settling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_ready_n <= 1'b1;
      reassert_r         <= 1'b0;
    end else if (sample_valid) begin
      conversion_ready_n <= ~conversion_ready_n;
      reassert_r         <= ~conversion_ready_n;
    end else if (reassert_r) begin
      conversion_ready_n <= 1'b0;
      reassert_r         <= 1'b0;
    end else if (sample_ack) begin
      conversion_ready_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Settling interval
  // ----------------------------------------------------------------
  logic [15:0] settle_cnt_r;

  // [R11] restart on reconfiguration or resync
  // [R12] count master periods to the table
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_r <= 16'h0000;
    end else if (resync || cfg_change) begin
      settle_cnt_r <= 16'h0000;
    end else if (mclk_rise && settle_cnt_r < SETTLE_TAB[idx]) begin
      settle_cnt_r <= settle_cnt_r + 16'h0001;
    end
  end

  assign settle_done = settle_cnt_r >= SETTLE_TAB[idx];

endmodule

// ### verilog/sdf_pkg.sv
// Behaviour
// [R1] The output is a linear-phase sinc low-pass average of the one-bit modulator stream.
// [R2] One output sample is made per selected-ratio count of modulator samples.
// [R3] A three-bit ratio field selects a ratio from the set 64 to 16384; the three-bit osr_sel here reaches only 64 to 8192.
// [R4] Nominal master and modulator rates are 8.192/4.096, 4.096/2.048 and 2.048/1.024 MHz.
// [R5] The stream feeds a third-order sinc path and a fast-settling path in parallel.
// [R6] After reset the output is taken from the first-order fast-settling path.
// [R7] After two conversions the output moves to the third-order path until the next reset.
// [R8] For ratios 64 to 1024 the third-order path decimates by the whole ratio.
// [R9] Above 1024 the third-order path decimates by 1024 and a first-order stage does 2 to 16.
// [R10] Plain boxcar sums give nulls at every multiple of the output rate.
// [R11] Enable, input, gain changes or a resync restart the settling interval.
// [R12] Settling lasts 728 to 33368 master clock periods for ratios 64 to 16384.
// [R13] Samples and the ready indication keep flowing while the filter settles.
// [R14] The host discards samples until the first ready edge after the settling interval.
// [R15] The modulator rate is exactly half the master clock rate.
// [R16] Ratio field values map in ascending order from 64.
// [R17] A resync clears integrator and comb state of both paths and restarts settling.
package sdf_pkg;

  // ----------------------------------------------------------------
  // Ratio selection
  // ----------------------------------------------------------------
  localparam int          SDF_OSR_W      = 3;
  localparam int          SDF_NUM_OSR    = 9;
  localparam logic [4:0]  SDF_OSR_LOG2_0 = 5'h06;
  localparam logic [4:0]  SDF_S3_LOG2MAX = 5'h0A;
  localparam logic [1:0]  SDF_FAST_CONVS = 2'h2;
  localparam int          SDF_MCLK_DIV   = 2;

  // ----------------------------------------------------------------
  // Nominal rates in kHz, kept for reference by software models
  // ----------------------------------------------------------------
  localparam int SDF_HR_MCLK_KHZ  = 8192;
  localparam int SDF_LP_MCLK_KHZ  = 4096;
  localparam int SDF_VLP_MCLK_KHZ = 2048;
  localparam int SDF_HR_MOD_KHZ   = SDF_HR_MCLK_KHZ / SDF_MCLK_DIV;
  localparam int SDF_LP_MOD_KHZ   = SDF_LP_MCLK_KHZ / SDF_MCLK_DIV;
  localparam int SDF_VLP_MOD_KHZ  = SDF_VLP_MCLK_KHZ / SDF_MCLK_DIV;

  // ----------------------------------------------------------------
  // Settling intervals in master clock periods, ratio 64 first
  // ----------------------------------------------------------------
  localparam logic [SDF_NUM_OSR-1:0][15:0] SDF_SETTLE_TAB = {
    16'h8258, 16'h4258, 16'h2258, 16'h1258, 16'h0A58,
    16'h0658, 16'h0458, 16'h0358, 16'h02D8
  };

  // ----------------------------------------------------------------
  // Datapath widths
  // ----------------------------------------------------------------
  localparam int SDF_S3_W   = 32;
  localparam int SDF_S1_W   = 36;
  localparam int SDF_FAST_W = 16;
  localparam int SDF_OUT_W  = 24;
  localparam int SDF_NORM_W = 48;

  typedef struct packed {
    logic [SDF_OUT_W-1:0] data;
    logic                 fast;
  } sdf_sample_t;

endpackage
